// >>> logic/cdag_defines.svh
`ifndef CDAG_DEFINES_SVH
`define CDAG_DEFINES_SVH
// ************************************************************
// Register offsets (word indices on the plain register port)
// ************************************************************
`define CDAG_ADDR_W        4
`define CDAG_OFF_STATUS    4'h0
`define CDAG_OFF_RDPAGE    4'h1
`define CDAG_OFF_WRPAGE    4'h2
`define CDAG_OFF_CORECTL   4'h3
`define CDAG_OFF_INTCTL1   4'h4
// ************************************************************
// Field positions and widths
// ************************************************************
`define CDAG_RDPAGE_W      10
`define CDAG_WRPAGE_W      9
`define CDAG_RDPAGE_TOP    9
`define CDAG_ADDR_TOP       15
`define CDAG_XADDR_W        24
`define CDAG_NEAR_W         13
`define CDAG_LIT5_W         5
`define CDAG_LIT10_W        10
`define CDAG_PRIO_LO        5
`define CDAG_PRIO_HI        7
`define CDAG_BIT_EITHER_OVF 11
`define CDAG_BIT_EITHER_SAT 10
`define CDAG_BIT_LOOP       9
`define CDAG_BIT_REPEAT     4
`define CDAG_CORECTL_PRIO3  3
`define CDAG_NEST_DIS_BIT   15
// ************************************************************
// Reset values
// ************************************************************
`define CDAG_STATUS_RST    16'h0000
`define CDAG_RDPAGE_RST    10'h001
`define CDAG_WRPAGE_RST    9'h001
`define CDAG_PRIO_MAX      3'h7
`endif

// >>> logic/cdag_pkg.sv
package cdag_pkg;
  typedef enum logic [2:0] {
    CDAG_MODE_FILE,
    CDAG_MODE_REG,
    CDAG_MODE_IND,
    CDAG_MODE_POST,
    CDAG_MODE_PRE,
    CDAG_MODE_IDX,
    CDAG_MODE_LIT
  } cdag_mode_t;
  typedef enum logic [1:0] {
    CDAG_DST_FILE,
    CDAG_DST_DEFAULT,
    CDAG_DST_DEFAULT_WORK_REG,
    CDAG_DST_PAIR
  } cdag_dst_t;
  typedef enum logic [1:0] {
    CDAG_SPC_BASE,
    CDAG_SPC_EXT,
    CDAG_SPC_PROGWIN
  } cdag_space_t;
endpackage : cdag_pkg

// >>> logic/cdag_ea_calc.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdag_defines.svh"
module cdag_ea_calc (
  input  wire logic               [2:0]  mode,
  input  wire logic               [15:0] pointerReg,
  input  wire logic               [15:0] indexReg,
  input  wire logic               [15:0] litOffset,
  input  wire logic signed        [15:0] modStep,
  input  wire logic [`CDAG_NEAR_W-1:0]   fileAddr,
  input  wire logic               [15:0] fullAddr,
  input  wire logic                      moveInstr,
  output logic                    [15:0] effectiveAddr,
  output logic                    [15:0] pointerNext,
  output logic                           pointerWrite
);
  wire logic [15:0] preSum  = 16'(pointerReg + modStep);
  wire logic [15:0] nearExt = {{(16-`CDAG_NEAR_W){1'b0}}, fileAddr};
  always_comb begin
    effectiveAddr = pointerReg;
    pointerNext   = pointerReg;
    pointerWrite  = 1'b0;
    unique case (cdag_pkg::cdag_mode_t'(mode))
      cdag_pkg::CDAG_MODE_FILE: begin
        effectiveAddr = moveInstr ? fullAddr : nearExt;
      end
      cdag_pkg::CDAG_MODE_REG: begin
        effectiveAddr = pointerReg;
      end
      cdag_pkg::CDAG_MODE_IND: begin
        effectiveAddr = pointerReg;
      end
      cdag_pkg::CDAG_MODE_POST: begin
        effectiveAddr = pointerReg;
        pointerNext   = preSum;
        pointerWrite  = 1'b1;
      end
      cdag_pkg::CDAG_MODE_PRE: begin
        effectiveAddr = preSum;
        pointerNext   = preSum;
        pointerWrite  = 1'b1;
      end
      cdag_pkg::CDAG_MODE_IDX: begin
        effectiveAddr = 16'(pointerReg + indexReg);
      end
      cdag_pkg::CDAG_MODE_LIT: begin
        effectiveAddr = 16'(pointerReg + litOffset);
      end
      default: begin
        effectiveAddr = pointerReg;
      end
    endcase
  end
endmodule : cdag_ea_calc
`default_nettype wire

// >>> logic/cdag_page_map.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdag_defines.svh"
module cdag_page_map (
  input  wire logic [15:0]                  effectiveAddr,
  input  wire logic                         isWrite,
  input  wire logic [`CDAG_RDPAGE_W-1:0]    readPage,
  input  wire logic [`CDAG_WRPAGE_W-1:0]    writePage,
  output logic      [`CDAG_XADDR_W-1:0]     extAddr,
  output logic      [1:0]                   space
);
  wire logic upper = effectiveAddr[`CDAG_ADDR_TOP];
  wire logic rdTop = readPage[`CDAG_RDPAGE_TOP];
  wire logic [`CDAG_WRPAGE_W-1:0] page = isWrite ? writePage
                                     : readPage[`CDAG_WRPAGE_W-1:0];
  always_comb begin
    if (!upper) begin
      extAddr = {8'h00, effectiveAddr};
      space   = 2'(cdag_pkg::CDAG_SPC_BASE);
    end else begin
      extAddr = {page, effectiveAddr[`CDAG_ADDR_TOP-1:0]};
      space   = (!isWrite && rdTop) ? 2'(cdag_pkg::CDAG_SPC_PROGWIN)
                                    : 2'(cdag_pkg::CDAG_SPC_EXT);
    end
  end
endmodule : cdag_page_map
`default_nettype wire

// >>> logic/cdag_addr_gen.sv
// Function
// - Read page register is 10 bits, write page register is 9 bits.
// - Read with page top 0 and address bit 15 set uses read page.
// - Write with address bit 15 set uses write page above bits 14:0.
// - Both page registers sit in the register space as locations.
// - File-register instructions reach the first 8192 bytes via 13 bits.
// - Default working register is register zero; multiply writes reg or pair (multiply here always selects CDAG_DST_PAIR).
// - Move instruction may address the whole data space.
// - Three-operand: source one register, source two register or 5-bit literal.
// - Supports direct, indirect, post, pre modified, 5 or 10 bit literals.
// - File direct uses encoded address; register direct uses contents.
// - Register indirect uses the pointer unchanged as address.
// - Post-modified accesses pointer value, then steps the pointer.
// - Pre-modified steps the pointer first, then uses the new value.
// - Indexed address is pointer plus second working register.
// - Literal offset address is pointer plus instruction literal.
// - Status bits 7:5 encode priority 0 to 7; 7 disables interrupts.
// - Core-control bit extends priority to 4 bits; set disables interrupts.
// - Priority field is read-only while nesting disable is set.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "cdag_defines.svh"
module cdag_addr_gen (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // ************************************************************
  // Register port
  // ************************************************************
  input  wire logic [`CDAG_ADDR_W-1:0]    regAddr,
  input  wire logic [15:0]                regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [15:0]                regRdata,
  // ************************************************************
  // Decode side
  // ************************************************************
  input  wire logic                       accValid,
  input  wire logic [2:0]                 accMode,
  input  wire logic                       accWrite,
  input  wire logic                       moveInstr,
  input  wire logic                       multiplyInstr,
  input  wire logic                       resultToFile,
  input  wire logic                       litLong,
  input  wire logic [`CDAG_NEAR_W-1:0]    fileAddr,
  input  wire logic [15:0]                fullAddr,
  input  wire logic [15:0]                pointerReg,
  input  wire logic [15:0]                indexReg,
  input  wire logic [`CDAG_LIT10_W-1:0]   literal,
  input  wire logic signed [15:0]         modStep,
  input  wire logic [15:0]                baseWorkReg,
  input  wire logic [15:0]                operandTwoReg,
  input  wire logic                       operandTwoLit,
  input  wire logic [6:0]                 statusFlagSet,
  input  wire logic                       loopActiveIn,
  input  wire logic                       repeatActiveIn,
  // ************************************************************
  // Memory side and core results
  // ************************************************************
  output logic      [`CDAG_XADDR_W-1:0]   memAddr,
  output logic      [1:0]                 memSpace,
  output logic                            memWrite,
  output logic                            memValid,
  output logic      [15:0]                pointerNext,
  output logic                            pointerWrite,
  output logic      [1:0]                 destSel,
  output logic      [15:0]                operandOne,
  output logic      [15:0]                operandTwo,
  output logic      [3:0]                 cpuPriorityLevel,
  output logic                            userIrqDisabled
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0]                 statusFf;
  logic [`CDAG_RDPAGE_W-1:0]   readPageFf;
  logic [`CDAG_WRPAGE_W-1:0]   writePageFf;
  logic                        corePrio3Ff;
  logic                        nestDisFf;
  logic [15:0]                 rdataFf;
  logic [`CDAG_XADDR_W-1:0]    memAddrFf;
  logic [1:0]                  memSpaceFf;
  logic                        memWriteFf;
  logic                        memValidFf;
  logic [15:0]                 ptrNextFf;
  logic                        ptrWrFf;
  logic [1:0]                  destFf;
  logic [15:0]                 opOneFf;
  logic [15:0]                 opTwoFf;

  wire logic selStatus = regAddr == `CDAG_OFF_STATUS;
  wire logic selRdPage = regAddr == `CDAG_OFF_RDPAGE;
  wire logic selWrPage = regAddr == `CDAG_OFF_WRPAGE;
  wire logic selCore   = regAddr == `CDAG_OFF_CORECTL;
  wire logic selIntc   = regAddr == `CDAG_OFF_INTCTL1;
  wire logic wrStatus  = regWr && selStatus;

  // ************************************************************
  // Address calculation
  // ************************************************************
  // Short literals are zero-extended on both operand paths
  function automatic logic [15:0] lit5Ext(
    input logic [`CDAG_LIT10_W-1:0] lit);
    return {{(16-`CDAG_LIT5_W){1'b0}}, lit[`CDAG_LIT5_W-1:0]};
  endfunction : lit5Ext
  wire logic [15:0] litExt = litLong ?
    {{(16-`CDAG_LIT10_W){1'b0}}, literal} : lit5Ext(literal);
  wire logic [15:0] addrNow;
  wire logic [15:0] ptrNow;
  wire logic        ptrWrNow;
  wire logic [`CDAG_XADDR_W-1:0] xAddr;
  wire logic [1:0]  spaceNow;

  cdag_ea_calc uEa (
    .mode          (accMode),
    .pointerReg    (pointerReg),
    .indexReg      (indexReg),
    .litOffset     (litExt),
    .modStep       (modStep),
    .fileAddr      (fileAddr),
    .fullAddr      (fullAddr),
    .moveInstr     (moveInstr),
    .effectiveAddr (addrNow),
    .pointerNext   (ptrNow),
    .pointerWrite  (ptrWrNow)
  );

  cdag_page_map uPage (
    .effectiveAddr (addrNow),
    .isWrite       (accWrite),
    .readPage      (readPageFf),
    .writePage     (writePageFf),
    .extAddr       (xAddr),
    .space         (spaceNow)
  );

  // Register direct operates on contents, no memory cycle
  wire logic memCycle = accValid &&
    (cdag_pkg::cdag_mode_t'(accMode) != cdag_pkg::CDAG_MODE_REG);
  wire logic [1:0] nxt_dest = multiplyInstr ?
    2'(cdag_pkg::CDAG_DST_PAIR) :
    (resultToFile ? 2'(cdag_pkg::CDAG_DST_FILE)
                  : 2'(cdag_pkg::CDAG_DST_DEFAULT));
  wire logic [15:0] nxt_opTwo = operandTwoLit ? lit5Ext(literal)
    : operandTwoReg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memAddrFf  <= '0;
      memSpaceFf <= '0;
      memWriteFf <= 1'b0;
      memValidFf <= 1'b0;
      ptrNextFf  <= '0;
      ptrWrFf    <= 1'b0;
      destFf     <= '0;
      opOneFf    <= '0;
      opTwoFf    <= '0;
    end else begin
      memAddrFf  <= xAddr;
      memSpaceFf <= spaceNow;
      memWriteFf <= memCycle && accWrite;
      memValidFf <= memCycle;
      ptrNextFf  <= ptrNow;
      ptrWrFf    <= accValid && ptrWrNow;
      destFf     <= nxt_dest;
      opOneFf    <= baseWorkReg;
      opTwoFf    <= nxt_opTwo;
    end
  end

  // ************************************************************
  // Status word and page registers
  // ************************************************************
  // Hardware set wins over a software clear in the same cycle
  logic [15:0] nxt_status;
  always_comb begin
    nxt_status = statusFf;
    if (wrStatus) begin
      nxt_status = regWdata;
      nxt_status[`CDAG_BIT_EITHER_OVF] = statusFf[`CDAG_BIT_EITHER_OVF]
                                         & regWdata[`CDAG_BIT_EITHER_OVF];
      nxt_status[`CDAG_BIT_EITHER_SAT] = statusFf[`CDAG_BIT_EITHER_SAT]
                                         & regWdata[`CDAG_BIT_EITHER_SAT];
      if (nestDisFf) begin
        nxt_status[`CDAG_PRIO_HI:`CDAG_PRIO_LO] =
          statusFf[`CDAG_PRIO_HI:`CDAG_PRIO_LO];
      end
    end
    nxt_status[`CDAG_BIT_EITHER_OVF] = nxt_status[`CDAG_BIT_EITHER_OVF]
                                       | statusFlagSet[0];
    nxt_status[`CDAG_BIT_EITHER_SAT] = nxt_status[`CDAG_BIT_EITHER_SAT]
                                       | statusFlagSet[1];
    nxt_status[`CDAG_BIT_LOOP]   = loopActiveIn;
    nxt_status[`CDAG_BIT_REPEAT] = repeatActiveIn;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      statusFf <= `CDAG_STATUS_RST;
    end else begin
      statusFf <= nxt_status;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readPageFf  <= `CDAG_RDPAGE_RST;
      writePageFf <= `CDAG_WRPAGE_RST;
      corePrio3Ff <= 1'b0;
      nestDisFf   <= 1'b0;
    end else if (regWr) begin
      if (selRdPage) readPageFf  <= regWdata[`CDAG_RDPAGE_W-1:0];
      if (selWrPage) writePageFf <= regWdata[`CDAG_WRPAGE_W-1:0];
      if (selCore) corePrio3Ff <= regWdata[`CDAG_CORECTL_PRIO3];
      if (selIntc) nestDisFf   <= regWdata[`CDAG_NEST_DIS_BIT];
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  wire logic [15:0] rdMux =
    selStatus ? statusFf :
    selRdPage ? {6'h00, readPageFf} :
    selWrPage ? {7'h00, writePageFf} :
    selCore   ? {12'h000, corePrio3Ff, 3'h0} :
    selIntc   ? {nestDisFf, 15'h0000} : 16'h0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdataFf <= '0;
    end else begin
      rdataFf <= regRd ? rdMux : 16'h0000;
    end
  end

  wire logic [2:0] prioLow = statusFf[`CDAG_PRIO_HI:`CDAG_PRIO_LO];

  assign regRdata         = rdataFf;
  assign memAddr          = memAddrFf;
  assign memSpace         = memSpaceFf;
  assign memWrite         = memWriteFf;
  assign memValid         = memValidFf;
  assign pointerNext      = ptrNextFf;
  assign pointerWrite     = ptrWrFf;
  assign destSel          = destFf;
  assign operandOne       = opOneFf;
  assign operandTwo       = opTwoFf;
  assign cpuPriorityLevel = {corePrio3Ff, prioLow};
  assign userIrqDisabled  = corePrio3Ff ||
                            (prioLow == `CDAG_PRIO_MAX);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_WR_PAGE: assert property (accValid && accWrite &&
    addrNow[`CDAG_ADDR_TOP] && accMode != 3'(cdag_pkg::CDAG_MODE_REG) |=>
    memAddr == {$past(writePageFf), $past(addrNow[`CDAG_ADDR_TOP-1:0])})
    else $error("write page address wrong");
  AST_RD_PAGE: assert property (accValid && !accWrite &&
    addrNow[`CDAG_ADDR_TOP] && !readPageFf[`CDAG_RDPAGE_TOP] |=>
    memAddr[`CDAG_XADDR_W-1:`CDAG_ADDR_TOP] ==
    $past(readPageFf[`CDAG_WRPAGE_W-1:0]) &&
    memSpace == 2'(cdag_pkg::CDAG_SPC_EXT))
    else $error("read page address wrong");
  AST_PROG_WIN: assert property (accValid && !accWrite &&
    addrNow[`CDAG_ADDR_TOP] && readPageFf[`CDAG_RDPAGE_TOP] |=>
    memSpace == 2'(cdag_pkg::CDAG_SPC_PROGWIN))
    else $error("program window not selected");
  AST_BASE: assert property (accValid && !addrNow[`CDAG_ADDR_TOP] |=>
    memAddr == {8'h00, $past(addrNow)})
    else $error("base address paged");
  AST_IND: assert property (accValid &&
    accMode == 3'(cdag_pkg::CDAG_MODE_IND) |=>
    memAddr[`CDAG_ADDR_TOP-1:0] == $past(pointerReg[`CDAG_ADDR_TOP-1:0]) &&
    !pointerWrite)
    else $error("indirect address wrong");
  AST_POST: assert property (accValid &&
    accMode == 3'(cdag_pkg::CDAG_MODE_POST) |=>
    memAddr[`CDAG_ADDR_TOP-1:0] == $past(pointerReg[`CDAG_ADDR_TOP-1:0]) &&
    pointerWrite && pointerNext == 16'($past(pointerReg) + $past(modStep)))
    else $error("post modify wrong");
  AST_PRE: assert property (accValid &&
    accMode == 3'(cdag_pkg::CDAG_MODE_PRE) |=> pointerWrite &&
    pointerNext[`CDAG_ADDR_TOP-1:0] == memAddr[`CDAG_ADDR_TOP-1:0])
    else $error("pre modify wrong");
  AST_PRIO_LOCK: assert property (nestDisFf && wrStatus |=>
    statusFf[`CDAG_PRIO_HI:`CDAG_PRIO_LO] ==
    $past(statusFf[`CDAG_PRIO_HI:`CDAG_PRIO_LO]))
    else $error("priority written while locked");
  AST_CLR_ONLY: assert property (!statusFf[`CDAG_BIT_EITHER_OVF] &&
    !statusFlagSet[0] |=> !statusFf[`CDAG_BIT_EITHER_OVF])
    else $error("overflow-either set by software");
  AST_IRQ_DIS: assert property (corePrio3Ff |-> userIrqDisabled &&
    cpuPriorityLevel[3])
    else $error("interrupts not disabled");
  AST_NEAR: assert property (accValid && !moveInstr &&
    accMode == 3'(cdag_pkg::CDAG_MODE_FILE) |=>
    memAddr[`CDAG_XADDR_W-1:`CDAG_NEAR_W] == '0 &&
    memAddr[`CDAG_NEAR_W-1:0] == $past(fileAddr))
    else $error("near address wrong");
  AST_REG_DIRECT: assert property (accValid &&
    accMode == 3'(cdag_pkg::CDAG_MODE_REG) |=> !memValid)
    else $error("memory cycle in register direct");
  AST_IDX: assert property (accValid &&
    accMode == 3'(cdag_pkg::CDAG_MODE_IDX) |=>
    memAddr[`CDAG_ADDR_TOP-1:0] == 15'($past(pointerReg) + $past(indexReg)))
    else $error("indexed address wrong");
  AST_DEST_PAIR: assert property (multiplyInstr |=>
    destSel == 2'(cdag_pkg::CDAG_DST_PAIR))
    else $error("multiply destination wrong");
  AST_OP_ONE: assert property (!rst |=>
    operandOne == $past(baseWorkReg))
    else $error("first operand wrong");
  AST_RD_LAT: assert property (regRd && selRdPage |=>
    regRdata == {6'h00, $past(readPageFf)})
    else $error("page readback wrong");

  COV_EXT_WR: cover property (memValid && memWrite &&
    memSpace == 2'(cdag_pkg::CDAG_SPC_EXT));
  COV_PROG: cover property (memSpace == 2'(cdag_pkg::CDAG_SPC_PROGWIN));
  COV_LOCK: cover property (nestDisFf && wrStatus);
  COV_LVL15: cover property (cpuPriorityLevel == 4'hF);
endmodule : cdag_addr_gen
`default_nettype wire

// >>> bench/cdag_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Data memory side
// ****************
// The core never waits on memory, so the model only observes and counts;
// it has no ready line that could stall an access.
module cdag_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [23:0] memAddr,
  input  wire logic [1:0]  memSpace,
  input  wire logic        memWrite,
  input  wire logic        memValid,
  output logic      [7:0]  accessCount,
  output logic      [7:0]  windowCount,
  output logic      [23:0] lastAddr
);
  logic [7:0]  accessCount_ff;
  logic [7:0]  windowCount_ff;
  logic [23:0] lastAddr_ff;
  logic        isWindow;
  // Program window reads only; a write there would be a core fault
  assign isWindow    = memValid && (memSpace == 2'h2) && !memWrite;
  assign accessCount = accessCount_ff;
  assign windowCount = windowCount_ff;
  assign lastAddr    = lastAddr_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accessCount_ff <= 8'h00;
      windowCount_ff <= 8'h00;
      lastAddr_ff    <= 24'h000000;
    end else if (memValid) begin
      accessCount_ff <= accessCount_ff + 8'h01;
      windowCount_ff <= windowCount_ff + {7'h00, isWindow};
      lastAddr_ff    <= memAddr;
    end
  end
endmodule : cdag_mem_model
`default_nettype wire

// >>> bench/cpu_data_address_generation_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdag_defines.svh"
module cpu_data_address_generation_tb_top;
  typedef struct packed {
    logic [2:0]  md;
    logic [4:0]  fl;
    logic [1:0]  dk;
    logic [15:0] ptr;
    logic [15:0] oth;
    logic [15:0] pn;
    logic [23:0] ma;
    logic [1:0]  sp;
  } cdag_row_t;
  // fl = {write, move, literal operand, pointer update, memory access}
  localparam cdag_row_t ROWS [9] = '{
    '{3'h0, 5'h01, 2'h0, 16'h0000, 16'hFFFF, 16'h0000, 24'h001FFF, 2'h0},
    '{3'h0, 5'h0D, 2'h1, 16'h0000, 16'hFFFF, 16'h0000, 24'h2AFFFF, 2'h1},
    '{3'h0, 5'h19, 2'h3, 16'h0000, 16'h8001, 16'h0000, 24'h550001, 2'h1},
    '{3'h1, 5'h04, 2'h1, 16'h1234, 16'h0011, 16'h0000, 24'h000000, 2'h0},
    '{3'h2, 5'h01, 2'h0, 16'h1234, 16'h0005, 16'h0000, 24'h001234, 2'h0},
    '{3'h3, 5'h07, 2'h1, 16'h1000, 16'hFFFE, 16'h0FFE, 24'h001000, 2'h0},
    '{3'h4, 5'h13, 2'h3, 16'h8000, 16'h0002, 16'h8002, 24'h550002, 2'h1},
    '{3'h5, 5'h05, 2'h0, 16'h7FFF, 16'h0001, 16'h0000, 24'h2A8000, 2'h1},
    '{3'h6, 5'h01, 2'h1, 16'h0100, 16'h03FF, 16'h0000, 24'h0004FF, 2'h0}
  };
  logic                      clk_sys, rst, regWr, regRd, accValid;
  logic [`CDAG_ADDR_W-1:0]   regAddr;
  logic [15:0]               regWdata, regRdata, fullAddr, pointerReg;
  logic [15:0]               indexReg, baseWorkReg, operandTwoReg;
  logic signed [15:0]        modStep;
  logic [2:0]                accMode;
  logic                      accWrite, moveInstr, multiplyInstr;
  logic                      resultToFile, litLong, operandTwoLit;
  logic                      loopActiveIn, repeatActiveIn;
  logic [`CDAG_NEAR_W-1:0]   fileAddr;
  logic [`CDAG_LIT10_W-1:0]  literal;
  logic [6:0]                statusFlagSet;
  logic [23:0]               memAddr, lastAddr;
  logic [1:0]                memSpace, destSel;
  logic                      memWrite, memValid, pointerWrite;
  logic                      userIrqDisabled;
  logic [15:0]               pointerNext, operandOne, operandTwo;
  logic [3:0]                cpuPriorityLevel;
  logic [7:0]                accessCount, windowCount;
  int                        nMismatch;
  int                        samplesChecked;
  cdag_addr_gen dut (.clk_sys, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .accValid, .accMode, .accWrite, .moveInstr, .multiplyInstr,
    .resultToFile, .litLong, .fileAddr, .fullAddr, .pointerReg, .indexReg,
    .literal, .modStep, .baseWorkReg, .operandTwoReg, .operandTwoLit,
    .statusFlagSet, .loopActiveIn, .repeatActiveIn, .memAddr, .memSpace,
    .memWrite, .memValid, .pointerNext, .pointerWrite, .destSel,
    .operandOne, .operandTwo, .cpuPriorityLevel, .userIrqDisabled);
  cdag_mem_model mem (.clk_sys, .rst, .memAddr, .memSpace, .memWrite,
    .memValid, .accessCount, .windowCount, .lastAddr);
  always #5 clk_sys = ~clk_sys;
  // ****************
  // Shared tasks
  // ****************
  task chk(input logic [23:0] got, input logic [23:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1 chk(24'(regRdata), 24'(e));
  endtask : rd
  task lvl(input logic [3:0] e, input logic d);
    #1 chk(24'(cpuPriorityLevel), 24'(e));
    chk(24'(userIrqDisabled), 24'(d));
  endtask : lvl
  task acc(input cdag_row_t r);
    @(posedge clk_sys);
    accMode       <= r.md;
    accWrite      <= r.fl[4];
    moveInstr     <= r.fl[3];
    operandTwoLit <= r.fl[2];
    multiplyInstr <= (r.dk == 2'h3);
    resultToFile  <= (r.dk == 2'h0);
    litLong       <= (r.md == 3'h6) && !r.fl[2];
    pointerReg    <= r.ptr;
    indexReg      <= r.oth;
    literal       <= r.oth[9:0];
    modStep       <= r.oth;
    fileAddr      <= r.oth[12:0];
    fullAddr      <= r.oth;
    accValid      <= 1'h1;
    @(posedge clk_sys);
    accValid <= 1'h0;
    #1 chk(24'(memValid), 24'(r.fl[0]));
    chk(24'(pointerWrite), 24'(r.fl[1]));
    chk(24'(destSel), 24'(r.dk));
    chk(24'(operandOne), 24'h00C3A5);
    chk(24'(operandTwo), r.fl[2] ? 24'(r.oth[4:0]) : 24'h005A5A);
    if (r.fl[0]) begin
      chk(memAddr, r.ma);
      chk(24'(memSpace), 24'(r.sp));
      chk(24'(memWrite), 24'(r.fl[4]));
    end
    if (r.fl[1]) begin
      chk(24'(pointerNext), 24'(r.pn));
    end
  endtask : acc
  task final_report;
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // ****************
  // Sequence
  // ****************
  initial begin
    clk_sys = 1'h0; rst = 1'h1; regAddr = '0; regWdata = '0;
    regWr = 1'h0; regRd = 1'h0; accValid = 1'h0; accMode = '0;
    accWrite = 1'h0; moveInstr = 1'h0; multiplyInstr = 1'h0;
    resultToFile = 1'h0; litLong = 1'h0; fileAddr = '0; fullAddr = '0;
    pointerReg = '0; indexReg = '0; literal = '0; modStep = '0;
    baseWorkReg = 16'hC3A5; operandTwoReg = 16'h5A5A; operandTwoLit = 1'h0;
    statusFlagSet = '0; loopActiveIn = 1'h0; repeatActiveIn = 1'h0;
    nMismatch = 0; samplesChecked = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    rd(`CDAG_OFF_STATUS, 16'h0000);
    rd(`CDAG_OFF_RDPAGE, 16'h0001);
    rd(`CDAG_OFF_WRPAGE, 16'h0001);
    lvl(4'h0, 1'h0);
    wr(`CDAG_OFF_RDPAGE, 16'hFFFF);
    rd(`CDAG_OFF_RDPAGE, 16'h03FF);
    wr(`CDAG_OFF_WRPAGE, 16'hFFFF);
    rd(`CDAG_OFF_WRPAGE, 16'h01FF);
    wr(`CDAG_OFF_RDPAGE, 16'h0055);
    wr(`CDAG_OFF_WRPAGE, 16'h00AA);
    for (int i = 0; i < 9; i++) begin
      acc(ROWS[i]);
    end
    acc('{3'h6, 5'h05, 2'h1, 16'h0100, 16'h03FF, 16'h0, 24'h00011F,
      2'h0});
    // Top page bit set: upper-half reads go to the program window only
    wr(`CDAG_OFF_RDPAGE, 16'h0201);
    acc('{3'h2, 5'h01, 2'h1, 16'h9234, 16'h0, 16'h0, 24'h009234, 2'h2});
    acc('{3'h2, 5'h11, 2'h1, 16'h9234, 16'h0, 16'h0, 24'h551234, 2'h1});
    wr(`CDAG_OFF_STATUS, 16'hFFFF);
    rd(`CDAG_OFF_STATUS, 16'hF1EF);
    lvl(4'h7, 1'h1);
    @(posedge clk_sys);
    statusFlagSet <= 7'h03;
    @(posedge clk_sys);
    statusFlagSet <= 7'h00;
    wr(`CDAG_OFF_STATUS, 16'hFFFF);
    rd(`CDAG_OFF_STATUS, 16'hFDEF);
    wr(`CDAG_OFF_STATUS, 16'h0000);
    rd(`CDAG_OFF_STATUS, 16'h0000);
    @(posedge clk_sys);
    loopActiveIn   <= 1'h1;
    repeatActiveIn <= 1'h1;
    wr(`CDAG_OFF_STATUS, 16'h0000);
    rd(`CDAG_OFF_STATUS, 16'h0210);
    loopActiveIn   <= 1'h0;
    repeatActiveIn <= 1'h0;
    wr(`CDAG_OFF_STATUS, 16'h0060);
    lvl(4'h3, 1'h0);
    wr(`CDAG_OFF_CORECTL, 16'h0008);
    lvl(4'hB, 1'h1);
    wr(`CDAG_OFF_CORECTL, 16'h0000);
    wr(`CDAG_OFF_INTCTL1, 16'h8000);
    wr(`CDAG_OFF_STATUS, 16'h00E0);
    lvl(4'h3, 1'h0);
    rd(`CDAG_OFF_STATUS, 16'h0060);
    wr(`CDAG_OFF_INTCTL1, 16'h0000);
    wr(`CDAG_OFF_STATUS, 16'h00E0);
    lvl(4'h7, 1'h1);
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000);
    rd(`CDAG_OFF_RDPAGE, 16'h0201);
    chk(24'(accessCount), 24'h00000B);
    chk(24'(windowCount), 24'h000001);
    chk(lastAddr, 24'h551234);
    @(posedge clk_sys);
    rst <= 1'h1;
    @(posedge clk_sys);
    rst <= 1'h0;
    rd(`CDAG_OFF_RDPAGE, 16'h0001);
    rd(`CDAG_OFF_STATUS, 16'h0000);
    lvl(4'h0, 1'h0);
    final_report;
  end
  // Whole run is under a hundred cycles; this margin only catches a hang
  initial begin
    repeat (3000) @(posedge clk_sys);
    nMismatch++;
    final_report;
  end
endmodule : cpu_data_address_generation_tb_top
`default_nettype wire
